// ---- design/ldcr_lane_d.sv ----
`timescale 1ns/10ps
`default_nettype none
module ldcr_lane_d (
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Classic Wishbone slave.
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [ldcr_pkg::LDCR_ADDR_W-1:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [ldcr_pkg::LDCR_DATA_W-1:0] WB_DAT_IN,
	output logic [ldcr_pkg::LDCR_DATA_W-1:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Device-wide register values, same clock domain.
	input wire logic [ldcr_pkg::LDCR_REG_W-1:0] GLOBAL_CONFIG_IN,
	input wire logic [ldcr_pkg::LDCR_REG_W-1:0] DEVICE_CONTROL_IN,
	// Lane status from the datapath, same clock domain.
	input wire logic SIGNAL_LOSS_FLAG_IN,
	input wire logic TEST_PATTERN_PASS_IN,
	input wire logic COMMA_DETECTED_IN,
	// Strap pins, asynchronous.
	input wire logic CONFIG_STRAP_HIGH_IN,
	input wire logic CONFIG_STRAP_LOW_IN,
	input wire logic TEST_PATTERN_STRAP_IN,
	input wire logic COMMA_ALIGN_STRAP_IN,
	input wire logic IO_STANDARD_HSTL_IN,
	// Effective lane settings.
	output logic CLK_TOL_COMP_OUT,
	output logic SIGNAL_LOSS_DETECT_OUT,
	output logic [1:0] CONFIG_OUT,
	output logic [1:0] EMPHASIS_OUT,
	output logic LOOPBACK_OUT,
	output logic TEST_PATTERN_OUT,
	output logic COMMA_ALIGN_OUT,
	output logic POWER_DOWN_OUT,
	output logic LANE_D_MULTIFUNCTION_PIN_OUT
);
	import ldcr_pkg::*;

	logic [LDCR_REG_W-1:0] lane_d_configuration;
	logic [LDCR_REG_W-1:0] next_lane_d_configuration;
	logic [LDCR_REG_W-1:0] write_mask;
	logic [LDCR_REG_W-1:0] effect_word;
	logic [LDCR_DATA_W-1:0] next_read_data;
	logic [LDCR_PIN_COUNT-1:0] pin_sync;
	logic config_strap_high;
	logic config_strap_low;
	logic test_pattern_strap;
	logic comma_align_strap;
	logic io_standard_hstl;
	logic bus_request;
	logic write_fire;
	logic [1:0] mf_select;
	logic next_mf_pin;

	// All strap pins share one synchroniser bank.
	ldcr_sync #(
		.WIDTH(LDCR_PIN_COUNT)
	) u_pin_sync (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.async_in({IO_STANDARD_HSTL_IN, COMMA_ALIGN_STRAP_IN, TEST_PATTERN_STRAP_IN,
			CONFIG_STRAP_LOW_IN, CONFIG_STRAP_HIGH_IN}),
		.sync_out(pin_sync)
	);

	assign config_strap_high = pin_sync[0];
	assign config_strap_low = pin_sync[1];
	assign test_pattern_strap = pin_sync[2];
	assign comma_align_strap = pin_sync[3];
	assign io_standard_hstl = pin_sync[4];

	// A request is acknowledged one cycle after it appears; ack then drops for a cycle.
	assign bus_request = WB_CYC_IN && WB_STB_IN;
	assign write_fire = bus_request && WB_WE_IN && WB_ACK_OUT && (WB_ADR_IN == LDCR_OFFSET_CONFIG);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			WB_ACK_OUT <= 1'b0;
		end else begin
			WB_ACK_OUT <= bus_request && !WB_ACK_OUT;
		end
	end

	// Byte lanes 0 and 1 cover the 16-bit register; the strap-locked bits keep their value.
	always_comb begin
		write_mask = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}} & LDCR_STORE_MASK;
		if (config_strap_high) begin
			write_mask[LDCR_BIT_CONFIG_HI] = 1'b0;
		end
		if (config_strap_low) begin
			write_mask[LDCR_BIT_CONFIG_LO] = 1'b0;
		end
		if (test_pattern_strap) begin
			write_mask[LDCR_BIT_PATTERN] = 1'b0;
		end
		next_lane_d_configuration = (lane_d_configuration & ~write_mask)
			| (WB_DAT_IN[LDCR_REG_W-1:0] & write_mask);
	end

	// The write lands at the edge where the master samples ack.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			lane_d_configuration <= LDCR_RESET_CONFIG;
		end else if (write_fire) begin
			lane_d_configuration <= next_lane_d_configuration;
		end
	end

	// The second register reports the merged settings, so software sees what the lane uses.
	assign effect_word = {4'h0, CLK_TOL_COMP_OUT, mf_select, SIGNAL_LOSS_DETECT_OUT, CONFIG_OUT,
		EMPHASIS_OUT, LOOPBACK_OUT, TEST_PATTERN_OUT, COMMA_ALIGN_OUT, POWER_DOWN_OUT};

	// Unmapped addresses still answer, with zero data, so a stray access never hangs.
	always_comb begin
		next_read_data = '0;
		case (WB_ADR_IN)
			LDCR_OFFSET_CONFIG: begin
				next_read_data[LDCR_REG_W-1:0] = lane_d_configuration & LDCR_STORE_MASK;
			end
			LDCR_OFFSET_EFFECT: begin
				next_read_data[LDCR_REG_W-1:0] = effect_word;
			end
			default: begin
				next_read_data = '0;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			WB_DAT_OUT <= '0;
		end else if (bus_request && !WB_ACK_OUT && !WB_WE_IN) begin
			WB_DAT_OUT <= next_read_data;
		end
	end

	// Select bits are merged before decode, so the global bits can only add to the choice.
	assign mf_select = lane_d_configuration[LDCR_BIT_MF_HI:LDCR_BIT_MF_LO]
		| GLOBAL_CONFIG_IN[LDCR_BIT_MF_HI:LDCR_BIT_MF_LO];

	always_comb begin
		case (mf_select)
			LDCR_MF_IO_STD: next_mf_pin = io_standard_hstl;
			LDCR_MF_COMMA: next_mf_pin = COMMA_DETECTED_IN;
			LDCR_MF_LOSS: next_mf_pin = SIGNAL_LOSS_FLAG_IN;
			LDCR_MF_PASS: next_mf_pin = TEST_PATTERN_PASS_IN;
			default: next_mf_pin = 1'b0;
		endcase
	end

	// Effective settings are flopped every cycle; one cycle of latency keeps outputs glitch free.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			CLK_TOL_COMP_OUT <= 1'b0;
			SIGNAL_LOSS_DETECT_OUT <= 1'b0;
			CONFIG_OUT <= 2'h0;
			EMPHASIS_OUT <= 2'h0;
			LOOPBACK_OUT <= 1'b0;
			TEST_PATTERN_OUT <= 1'b0;
			COMMA_ALIGN_OUT <= 1'b0;
			POWER_DOWN_OUT <= 1'b0;
			LANE_D_MULTIFUNCTION_PIN_OUT <= 1'b0;
		end else begin
			CLK_TOL_COMP_OUT <= lane_d_configuration[LDCR_BIT_CLK_TOL]
				| GLOBAL_CONFIG_IN[LDCR_BIT_CLK_TOL];
			SIGNAL_LOSS_DETECT_OUT <= lane_d_configuration[LDCR_BIT_LOSS_DET]
				& GLOBAL_CONFIG_IN[LDCR_BIT_LOSS_DET];
			CONFIG_OUT[1] <= lane_d_configuration[LDCR_BIT_CONFIG_HI]
				| GLOBAL_CONFIG_IN[LDCR_BIT_CONFIG_HI];
			CONFIG_OUT[0] <= lane_d_configuration[LDCR_BIT_CONFIG_LO]
				| GLOBAL_CONFIG_IN[LDCR_BIT_CONFIG_LO];
			EMPHASIS_OUT <= lane_d_configuration[LDCR_BIT_EMPH_HI:LDCR_BIT_EMPH_LO]
				| GLOBAL_CONFIG_IN[LDCR_BIT_EMPH_HI:LDCR_BIT_EMPH_LO];
			LOOPBACK_OUT <= lane_d_configuration[LDCR_BIT_LOOPBACK]
				| DEVICE_CONTROL_IN[LDCR_R0_BIT_LOOPBACK];
			TEST_PATTERN_OUT <= lane_d_configuration[LDCR_BIT_PATTERN]
				| GLOBAL_CONFIG_IN[LDCR_BIT_PATTERN];
			COMMA_ALIGN_OUT <= lane_d_configuration[LDCR_BIT_COMMA] & comma_align_strap
				& GLOBAL_CONFIG_IN[LDCR_BIT_COMMA];
			POWER_DOWN_OUT <= lane_d_configuration[LDCR_BIT_POWER_DOWN]
				| DEVICE_CONTROL_IN[LDCR_R0_BIT_POWER_DOWN];
			LANE_D_MULTIFUNCTION_PIN_OUT <= next_mf_pin;
		end
	end

	// Reserved bits never hold a one, whatever was written.
	AST_RESERVED_ZERO: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(lane_d_configuration[15:12] == 4'h0) && (!WB_ACK_OUT || WB_WE_IN || WB_DAT_OUT[31:12] == 20'h0))
		else $error("reserved configuration bits are not zero");

	// Compensation follows the OR of both sources one cycle later.
	AST_CLK_TOL_OR: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		RESETN_IN |=> CLK_TOL_COMP_OUT == ($past(lane_d_configuration[LDCR_BIT_CLK_TOL])
		| $past(GLOBAL_CONFIG_IN[LDCR_BIT_CLK_TOL])))
		else $error("clock tolerance enable is not the OR of its sources");

	// With select 00 the pin shows the synchronised I/O standard level.
	AST_MF_IO_STD: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(lane_d_configuration[10:9] == 2'h0 && GLOBAL_CONFIG_IN[10:9] == 2'h0)
		|=> LANE_D_MULTIFUNCTION_PIN_OUT == $past(io_standard_hstl))
		else $error("multifunction pin does not show the I/O standard");

	// With the merged select at 10 or 11 the pin shows the matching status flag.
	AST_MF_STATUS: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RESETN_IN && mf_select[1]) |=> LANE_D_MULTIFUNCTION_PIN_OUT == ($past(mf_select[0])
		? $past(TEST_PATTERN_PASS_IN) : $past(SIGNAL_LOSS_FLAG_IN)))
		else $error("multifunction pin does not show the selected status flag");

	// A global select bit forces the matching decode bit even when the lane bit is zero.
	AST_MF_MERGE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RESETN_IN && GLOBAL_CONFIG_IN[10:9] == 2'h1 && lane_d_configuration[10:9] == 2'h0)
		|=> LANE_D_MULTIFUNCTION_PIN_OUT == $past(COMMA_DETECTED_IN))
		else $error("global select bits are not merged into the decode");

	// Loss detection needs both enables.
	AST_LOSS_AND: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		SIGNAL_LOSS_DETECT_OUT |-> $past(lane_d_configuration[LDCR_BIT_LOSS_DET])
		&& $past(GLOBAL_CONFIG_IN[LDCR_BIT_LOSS_DET]))
		else $error("loss detection active without both enables");

	// A locked configuration bit ignores writes.
	AST_CONFIG_HI_LOCK: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(write_fire && config_strap_high) |=> $stable(lane_d_configuration[LDCR_BIT_CONFIG_HI]))
		else $error("configuration bit 7 changed while its strap was high");

	AST_CONFIG_LO_LOCK: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(write_fire && config_strap_low) |=> $stable(lane_d_configuration[LDCR_BIT_CONFIG_LO]))
		else $error("configuration bit 6 changed while its strap was high");

	// A write with byte lane 0 set stores the written emphasis and loopback bits.
	AST_WRITE_TAKES: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(write_fire && WB_SEL_IN[0]) |=> lane_d_configuration[5:3] == $past(WB_DAT_IN[5:3]))
		else $error("unlocked write did not store its data");

	// Loopback and power down follow register 0 as well as the lane bits.
	AST_DEVICE_MERGE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		RESETN_IN |=> (LOOPBACK_OUT == ($past(lane_d_configuration[3])
		| $past(DEVICE_CONTROL_IN[14])))
		&& (POWER_DOWN_OUT == ($past(lane_d_configuration[0]) | $past(DEVICE_CONTROL_IN[11]))))
		else $error("loopback or power down ignores a source");

	AST_PATTERN_LOCK: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(write_fire && test_pattern_strap) |=> $stable(lane_d_configuration[LDCR_BIT_PATTERN]))
		else $error("test pattern bit changed while its strap was high");

	// Comma alignment drops within a cycle of any of its three enables going low.
	AST_COMMA_AND: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(!comma_align_strap || !GLOBAL_CONFIG_IN[1] || !lane_d_configuration[1]) |=> !COMMA_ALIGN_OUT)
		else $error("comma alignment active without all enables");

	AST_POWER_DOWN_SET: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		lane_d_configuration[0] |=> POWER_DOWN_OUT)
		else $error("power down bit did not take effect");

	// Emphasis tracks a change in its global register bits 5:4 within one cycle.
	AST_NEXT_CYCLE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RESETN_IN && $changed(GLOBAL_CONFIG_IN[5:4]))
		|=> EMPHASIS_OUT == ($past(lane_d_configuration[5:4])
		| $past(GLOBAL_CONFIG_IN[5:4])))
		else $error("emphasis did not follow its sources on the next cycle");

	// Every request is answered in the next cycle, so a master never waits longer.
	AST_ACK_ANSWER: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(bus_request && !WB_ACK_OUT) |=> WB_ACK_OUT)
		else $error("request was not acknowledged in the next cycle");

	// A configuration read hands back the stored bits with every reserved bit clear.
	AST_READ_CONFIG: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(bus_request && !WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == LDCR_OFFSET_CONFIG)
		|=> WB_DAT_OUT == {20'h0, $past(lane_d_configuration[LDCR_BIT_CLK_TOL:0])})
		else $error("configuration read returned the wrong value");

	// Writes to any other place leave the stored register alone.
	AST_OTHER_WRITE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(bus_request && WB_WE_IN && WB_ADR_IN != LDCR_OFFSET_CONFIG) |=> $stable(lane_d_configuration))
		else $error("a write to another place changed the register");

	// Loss detection comes on when both enables are set.
	AST_LOSS_SET: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RESETN_IN && lane_d_configuration[8] && GLOBAL_CONFIG_IN[8]) |=> SIGNAL_LOSS_DETECT_OUT)
		else $error("loss detection stayed off with both enables set");

	// Both configuration outputs follow the OR of their two sources.
	AST_CONFIG_OR: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		RESETN_IN |=> CONFIG_OUT == ($past(lane_d_configuration[7:6]) | $past(GLOBAL_CONFIG_IN[7:6])))
		else $error("configuration outputs are not the OR of their sources");

	// An unlocked write with byte lane 0 set stores the written configuration bit.
	AST_CONFIG_OPEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(write_fire && !config_strap_high && WB_SEL_IN[0])
		|=> lane_d_configuration[LDCR_BIT_CONFIG_HI] == $past(WB_DAT_IN[LDCR_BIT_CONFIG_HI]))
		else $error("configuration bit 7 ignored a write while its strap was low");

	// The test pattern enable follows the OR of the lane and global bits.
	AST_PATTERN_OR: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		RESETN_IN |=> TEST_PATTERN_OUT == ($past(lane_d_configuration[2]) | $past(GLOBAL_CONFIG_IN[2])))
		else $error("test pattern enable is not the OR of its sources");

	// Comma alignment comes on once all three enables are set.
	AST_COMMA_SET: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(RESETN_IN && comma_align_strap && GLOBAL_CONFIG_IN[1] && lane_d_configuration[1])
		|=> COMMA_ALIGN_OUT)
		else $error("comma alignment stayed off with all enables set");

	// Ack never stands for two cycles running.
	AST_ACK_PULSE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack stayed high for two cycles");
endmodule : ldcr_lane_d
`default_nettype wire

// ---- design/ldcr_pkg.sv ----
// Notes on behaviour
// - Bits 15:12 of the lane configuration register always read as zero and writes to them are dropped.
// - Bit 11 enables clock tolerance compensation, resets to 0, and is ORed with global register bit 11.
// - Multifunction select 00 shows the I/O standard level (1 for HSTL, 0 for SSTL_2) and 01 shows comma detection.
// - Multifunction select 10 shows the lane signal loss flag and 11 shows the lane test pattern pass flag.
// - Each multifunction select bit is ORed with the matching global register bit before decoding.
// - Bit 8 enables signal loss detection, resets to 1, and is ANDed with global register bit 8.
// - Configuration bit 7 resets to 0, is ORed with global bit 7, and is writable only while its strap is low.
// - Configuration bit 6 resets to 0, is ORed with global bit 6, and is writable only while its strap is low.
// - Emphasis bits 5 and 4 reset to 0 and are each ORed with the same global register bit.
// - Bit 3 enables loopback, resets to 0, and is ORed with bit 14 of register 0.
// - Bit 2 enables test patterns, resets to 0, is ORed with global bit 2, and is locked while its strap is high.
// - Bit 1 enables comma alignment, resets to 1, and is ANDed with the alignment strap and global bit 1.
// - Bit 0 enables power down, resets to 0, and is ORed with bit 11 of register 0.
package ldcr_pkg;
	// Bus geometry.
	localparam int LDCR_ADDR_W = 8;
	localparam int LDCR_DATA_W = 32;
	localparam int LDCR_REG_W = 16;
	// Register byte offsets.
	localparam logic [LDCR_ADDR_W-1:0] LDCR_OFFSET_CONFIG = 8'h00;
	localparam logic [LDCR_ADDR_W-1:0] LDCR_OFFSET_EFFECT = 8'h04;
	// Field positions.
	localparam int LDCR_BIT_CLK_TOL = 11;
	localparam int LDCR_BIT_MF_HI = 10;
	localparam int LDCR_BIT_MF_LO = 9;
	localparam int LDCR_BIT_LOSS_DET = 8;
	localparam int LDCR_BIT_CONFIG_HI = 7;
	localparam int LDCR_BIT_CONFIG_LO = 6;
	localparam int LDCR_BIT_EMPH_HI = 5;
	localparam int LDCR_BIT_EMPH_LO = 4;
	localparam int LDCR_BIT_LOOPBACK = 3;
	localparam int LDCR_BIT_PATTERN = 2;
	localparam int LDCR_BIT_COMMA = 1;
	localparam int LDCR_BIT_POWER_DOWN = 0;
	// Register 0 bit positions that merge into this lane.
	localparam int LDCR_R0_BIT_LOOPBACK = 14;
	localparam int LDCR_R0_BIT_POWER_DOWN = 11;
	// Reset value and the mask of bits that can hold a value.
	localparam logic [LDCR_REG_W-1:0] LDCR_RESET_CONFIG = 16'h0102;
	localparam logic [LDCR_REG_W-1:0] LDCR_STORE_MASK = 16'h0fff;
	// Multifunction pin selections.
	localparam logic [1:0] LDCR_MF_IO_STD = 2'h0;
	localparam logic [1:0] LDCR_MF_COMMA = 2'h1;
	localparam logic [1:0] LDCR_MF_LOSS = 2'h2;
	localparam logic [1:0] LDCR_MF_PASS = 2'h3;
	// Number of pin inputs that pass through the synchroniser.
	localparam int LDCR_PIN_COUNT = 5;
endpackage : ldcr_pkg

// ---- design/ldcr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module ldcr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Asynchronous levels and their synchronised copies.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// Refuse at elaboration a width that leaves no bit to carry.
	if (WIDTH < 1) begin : g_width_check
		$error("ldcr_sync needs a width of at least one");
	end

	// Two flops in series; only the second flop reads the first.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule : ldcr_sync
`default_nettype wire

// ---- tb/ldcr_testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	import ldcr_pkg::*;
	typedef struct {bit chk; logic [31:0] val; bit prt; logic [10:0] pv;} ldcr_note_type;
	logic clk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [15:0] g = 16'h0, dc = 16'h0;
	logic loss = 1'h0, pass = 1'h0, comma = 1'h0, hstl = 1'h0;
	logic s_hi = 1'h0, s_lo = 1'h0, s_pat = 1'h0, s_al = 1'h0;
	logic [31:0] rdat;
	logic ack, clk_tol, loss_det, lpbk, pat, align, pd, pin;
	logic [1:0] cfg_o, emph_o;
	int fails = 0;
	int comparisons = 0;
	logic [15:0] shadow = 16'h0102;
	ldcr_note_type notes[$];
	ldcr_note_type cur;

	ldcr_lane_d ldcr_lane_d_inst (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .GLOBAL_CONFIG_IN(g), .DEVICE_CONTROL_IN(dc), .SIGNAL_LOSS_FLAG_IN(loss),
		.TEST_PATTERN_PASS_IN(pass), .COMMA_DETECTED_IN(comma), .CONFIG_STRAP_HIGH_IN(s_hi),
		.CONFIG_STRAP_LOW_IN(s_lo), .TEST_PATTERN_STRAP_IN(s_pat), .COMMA_ALIGN_STRAP_IN(s_al),
		.IO_STANDARD_HSTL_IN(hstl), .CLK_TOL_COMP_OUT(clk_tol), .SIGNAL_LOSS_DETECT_OUT(loss_det),
		.CONFIG_OUT(cfg_o), .EMPHASIS_OUT(emph_o), .LOOPBACK_OUT(lpbk), .TEST_PATTERN_OUT(pat),
		.COMMA_ALIGN_OUT(align), .POWER_DOWN_OUT(pd), .LANE_D_MULTIFUNCTION_PIN_OUT(pin));

	// Free-running management clock at 25 MHz.
	always #20 clk = ~clk;

	// Effective settings as the merge of register, global bits, device control and strap.
	function automatic logic [11:0] eff_f(input logic [15:0] c);
		logic [11:0] e;
		e = c[11:0] | g[11:0];
		e[8] = c[8] & g[8];
		e[3] = c[3] | dc[LDCR_R0_BIT_LOOPBACK];
		e[1] = c[1] & g[1] & s_al;
		e[0] = c[0] | dc[LDCR_R0_BIT_POWER_DOWN];
		return e;
	endfunction : eff_f

	// Pin level picked by the merged select.
	function automatic logic pin_f(input logic [11:0] e);
		case (e[10:9])
			LDCR_MF_IO_STD: return hstl;
			LDCR_MF_COMMA: return comma;
			LDCR_MF_LOSS: return loss;
			default: return pass;
		endcase
	endfunction : pin_f

	// Stored value after a write; locked bits keep their value while the strap is high.
	function automatic logic [15:0] upd(input logic [15:0] o, input logic [3:0] s, input logic [31:0] d);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & LDCR_STORE_MASK;
		if (s_hi) m[7] = 1'h0;
		if (s_lo) m[6] = 1'h0;
		if (s_pat) m[2] = 1'h0;
		return (o & ~m) | (d[15:0] & m);
	endfunction : upd

	// Prints the counts and the verdict, then stops the run.
	task automatic tally_and_finish();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// One classic Wishbone cycle; the expected answer is noted before the request goes out.
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		input bit prt);
		int n;
		ldcr_note_type nt;
		logic [11:0] e;
		e = eff_f(shadow);
		nt.chk = !w;
		nt.prt = prt && !w;
		nt.pv = {e[11], e[8:0], pin_f(e)};
		nt.val = (a == LDCR_OFFSET_CONFIG) ? {16'h0, shadow} : 32'h0;
		if (a == LDCR_OFFSET_EFFECT) nt.val = {20'h0, e};
		notes.push_back(nt);
		if (w && a == LDCR_OFFSET_CONFIG) shadow = upd(shadow, s, d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
	endtask : bus

	// Reads back the register and the effective word, with the setting ports.
	task automatic chk_both(input string name);
		bus(1'h0, LDCR_OFFSET_CONFIG, 4'hf, 32'h0, 1'b0);
		bus(1'h0, LDCR_OFFSET_EFFECT, 4'hf, 32'h0, 1'b1);
		$display("test %s done", name);
	endtask : chk_both

	// Watcher: each acknowledge retires the oldest note and compares what it promised.
	always @(posedge clk) begin
		if (ack === 1'h1) begin
			if (notes.size() == 0) begin
				`CHK(1'h1, 1'h0)
			end else begin
				cur = notes.pop_front();
				if (cur.chk) `CHK(rdat, cur.val)
				if (cur.prt) `CHK({clk_tol, loss_det, cfg_o, emph_o, lpbk, pat, align, pd, pin}, cur.pv)
			end
		end
	end

	// Main sequence: reset values, reserved and byte writes, refused places, random merges.
	initial begin
		int i;
		logic [15:0] r;
		void'($urandom(6));
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		repeat (4) @(posedge clk);
		chk_both("reset values");
		bus(1'h1, LDCR_OFFSET_CONFIG, 4'hf, 32'hffffffff, 1'b0);
		chk_both("reserved bits");
		bus(1'h1, LDCR_OFFSET_CONFIG, 4'h1, 32'h0, 1'b0);
		chk_both("byte select");
		bus(1'h1, LDCR_OFFSET_EFFECT, 4'hf, 32'h0000ffff, 1'b0);
		bus(1'h1, 8'h08, 4'hf, 32'h0000ffff, 1'b0);
		bus(1'h0, 8'h08, 4'hf, 32'h0, 1'b0);
		chk_both("refused places");
		for (i = 0; i < 24; i++) begin
			r = 16'($urandom);
			if (i < 8) r[10:9] = 2'h0;
			else if (i < 12) r[10:9] = 2'h1;
			g <= r;
			dc <= 16'($urandom);
			{loss, pass, comma, s_hi, s_lo, s_pat, s_al, hstl} <= 8'($urandom);
			repeat (4) @(posedge clk);
			r = 16'($urandom);
			if (i < 8) r[10:9] = i[1:0];
			else if (i < 12) r[10:9] = 2'h0;
			bus(1'h1, LDCR_OFFSET_CONFIG, (i < 12) ? 4'h3 : 4'($urandom), {16'($urandom), r}, 1'b0);
			chk_both("random merge");
		end
		@(posedge clk);
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		shadow = LDCR_RESET_CONFIG;
		repeat (4) @(posedge clk);
		chk_both("second reset");
		@(posedge clk);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
